//--- rtl/port_pattern_match_irq.sv
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module port_pattern_match_irq
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Port pins
    input  wire logic [7:0]  port_in,
    // Core side
    input  wire logic        low_power,
    output logic             port_match_interrupt,
    output logic             wake_request
);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and event state.
    logic [7:0]  pin_match_mask_reg;
    logic [7:0]  match_pattern_reg;
    logic        pattern_match_flag_reg;
    logic        compare_sense_select_reg;
    logic        active_reg;
    logic        match_ie_reg;
    logic [1:0]  status_reg;
    logic [1:0]  status_next;
    logic [1:0]  status_mask_reg;
    logic [3:0]  hold_reg;
    logic [3:0]  hold_next;
    // Decoded bus and match terms.
    logic        condition;
    logic        qualified;
    logic        write_access;
    logic        read_access;
    logic        setup_phase;
    logic        control_write;
    logic        flag_clear;
    logic [1:0]  status_set;
    logic [1:0]  status_clear;
    logic        irq_next;
    logic        wake_next;
    logic [31:0] read_word;

    ////////////////////////////////////////////////////////////////////////////
    // Registers decode on the word index, so the two low address bits are ignored.
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        is_addr = (a[7:2] == b[7:2]);
    endfunction

    // Every word past the last register is refused with an error response.
    function automatic logic is_unmapped(input logic [7:0] a);
        is_unmapped = (a[7:2] > port_match_pkg::addr_port[7:2]);
    endfunction

    // Pins that take part and differ from the pattern; unmasked pins never count.
    function automatic logic [7:0] differing_pins(input logic [7:0] pins,
                                                  input logic [7:0] pattern,
                                                  input logic [7:0] mask);
        differing_pins = (pins ^ pattern) & mask;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign setup_phase   = psel && !penable;
    assign write_access  = psel && penable && pwrite;
    assign read_access   = setup_phase && !pwrite;
    assign control_write = write_access && is_addr(paddr, port_match_pkg::addr_control);
    assign flag_clear    = control_write && !pwdata[port_match_pkg::ctrl_flag_bit];

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [7:0] diff;
        diff = differing_pins(port_in, match_pattern_reg, pin_match_mask_reg);
        if (compare_sense_select_reg)
        begin
            condition = (diff != 8'h00);
        end
        else
        begin
            condition = (diff == 8'h00);
        end
    end

    // Counting from zero on every break filters short glitches on the pins.
    always_comb
    begin
        if (!active_reg || !condition)
        begin
            hold_next = 4'h0;
        end
        else if (hold_reg != port_match_pkg::hold_count)
        begin
            hold_next = hold_reg + 4'h1;
        end
        else
        begin
            hold_next = hold_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            hold_reg <= 4'h0;
        end
        else
        begin
            hold_reg <= hold_next;
        end
    end

    // The count saturates, so a steady match keeps qualifying every cycle.
    assign qualified = active_reg && (hold_reg == port_match_pkg::hold_count);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pin_match_mask_reg <= port_match_pkg::mask_reset;
        end
        else if (write_access && is_addr(paddr, port_match_pkg::addr_mask))
        begin
            pin_match_mask_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            match_pattern_reg <= port_match_pkg::pattern_reset;
        end
        else if (write_access && is_addr(paddr, port_match_pkg::addr_pattern))
        begin
            match_pattern_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            status_mask_reg <= 2'h0;
        end
        else if (write_access && is_addr(paddr, port_match_pkg::addr_irq_en))
        begin
            status_mask_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            compare_sense_select_reg <= 1'b0;
            active_reg               <= 1'b0;
            match_ie_reg             <= 1'b0;
        end
        else if (control_write)
        begin
            compare_sense_select_reg <= pwdata[port_match_pkg::ctrl_sense_bit];
            active_reg               <= pwdata[port_match_pkg::ctrl_active_bit];
            match_ie_reg             <= pwdata[port_match_pkg::ctrl_ie_bit];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pattern_match_flag_reg <= 1'b0;
        end
        else if (qualified)
        begin
            pattern_match_flag_reg <= 1'b1;
        end
        else if (flag_clear)
        begin
            pattern_match_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status: match event and wake event, cleared by writing one.
    always_comb
    begin
        status_set                                 = 2'h0;
        status_set[port_match_pkg::stat_match_bit] = qualified;
        status_set[port_match_pkg::stat_wake_bit]  = qualified && low_power;
    end

    always_comb
    begin
        status_clear = 2'h0;
        if (write_access && is_addr(paddr, port_match_pkg::addr_status))
        begin
            status_clear = pwdata[1:0];
        end
    end

    // Setting last lets a new event survive a clear in the same cycle.
    assign status_next = (status_reg & ~status_clear) | status_set;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            status_reg <= 2'h0;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Both requests leave flip-flops, so the core never sees a decode glitch.
    assign irq_next  = (match_ie_reg && pattern_match_flag_reg)
                       || ((status_reg & status_mask_reg) != 2'h0);
    assign wake_next = low_power && match_ie_reg
                       && (pattern_match_flag_reg || qualified);

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            port_match_interrupt <= 1'b0;
        end
        else
        begin
            port_match_interrupt <= irq_next;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            wake_request <= 1'b0;
        end
        else
        begin
            wake_request <= wake_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data is captured in the setup cycle so the access phase completes at once.
    always_comb
    begin
        read_word = 32'h0000_0000;
        unique case (paddr[7:2])
            port_match_pkg::addr_control[7:2]:
            begin
                read_word[port_match_pkg::ctrl_flag_bit]   = pattern_match_flag_reg;
                read_word[port_match_pkg::ctrl_sense_bit]  = compare_sense_select_reg;
                read_word[port_match_pkg::ctrl_active_bit] = active_reg;
                read_word[port_match_pkg::ctrl_ie_bit]     = match_ie_reg;
            end
            port_match_pkg::addr_mask[7:2]:    read_word[7:0] = pin_match_mask_reg;
            port_match_pkg::addr_pattern[7:2]: read_word[7:0] = match_pattern_reg;
            port_match_pkg::addr_status[7:2]:  read_word[1:0] = status_reg;
            port_match_pkg::addr_irq_en[7:2]:  read_word[1:0] = status_mask_reg;
            port_match_pkg::addr_port[7:2]:    read_word[7:0] = port_in;
            default:
            begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup_phase;
            pslverr <= setup_phase && is_unmapped(paddr);
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (read_access)
        begin
            prdata <= read_word;
        end
    end

endmodule

//--- common/port_match_pkg.sv
package port_match_pkg;

    // Register byte addresses on the APB.
    localparam logic [7:0] addr_control = 8'h00;
    localparam logic [7:0] addr_mask    = 8'h04;
    localparam logic [7:0] addr_pattern = 8'h08;
    localparam logic [7:0] addr_status  = 8'h0C;
    localparam logic [7:0] addr_irq_en  = 8'h10;
    localparam logic [7:0] addr_port    = 8'h14;

    // Control register fields.
    localparam int ctrl_flag_bit   = 0;
    localparam int ctrl_sense_bit  = 1;
    localparam int ctrl_active_bit = 2;
    localparam int ctrl_ie_bit     = 3;

    // Interrupt status bits.
    localparam int stat_match_bit = 0;
    localparam int stat_wake_bit  = 1;

    // Reset values.
    localparam logic [7:0] mask_reset    = 8'h00;
    localparam logic [7:0] pattern_reset = 8'hFF;

    // Persistence: the pattern must hold longer than six core clocks.
    localparam int          hold_clocks = 6;
    localparam logic [3:0]  hold_count  = 4'(hold_clocks + 1);

endpackage

//--- verif/keypad_model.sv
`timescale 1ns/1ns
module keypad_model
(
    // Control
    input  wire logic       clock,
    input  wire logic [7:0] keys,
    // Port pins
    output logic      [7:0] port_in
);
    // Keys reach the pins on a clock edge, so a press lasts whole clocks.
    always_ff @(posedge clock)
    begin
        port_in <= keys;
    end
endmodule

//--- verif/match_irq_sva.sv
`timescale 1ns/1ns
module match_irq_sva
(
    // Clock and reset
    input wire logic       clock,
    input wire logic       reset,
    // APB
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    // Core side
    input wire logic       low_power,
    input wire logic       port_match_interrupt,
    input wire logic       wake_request
);
    logic wr;
    assign wr = psel && penable && pwrite;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_ready_access: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_setup: assert property (psel && !penable |-> !pready)
        else $error("ready in setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    a_err_map: assert property (pready |-> pslverr == (paddr[7:2] > port_match_pkg::addr_port[7:2]))
        else $error("bad error flag");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_wake_power: assert property (wake_request |-> $past(low_power))
        else $error("wake while running");
    a_wake_drop: assert property (!low_power |=> !wake_request)
        else $error("wake not dropped");
    a_irq_sticky: assert property ($fell(port_match_interrupt) |-> $past(wr) || $past(wr, 2))
        else $error("interrupt dropped alone");
endmodule
bind port_pattern_match_irq match_irq_sva i_match_irq_sva (.clock, .reset, .psel, .penable,
    .pwrite, .paddr, .pready, .pslverr, .low_power, .port_match_interrupt, .wake_request);

//--- verif/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic        clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, low_power = 0;
    logic [7:0]  paddr = 8'h00, keys = 8'hFF, port_in;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq, wake, err;
    int          bad_count = 0, checks_done = 0;
    port_pattern_match_irq i_port_pattern_match_irq (.clock, .reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .port_in, .low_power,
        .port_match_interrupt(irq), .wake_request(wake));
    keypad_model i_keypad_model (.clock, .keys, .port_in);
    initial forever #2 clock = ~clock;
    ////////////////////////////////////////
    // Setup, then access held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps the next request off this release.
        @(posedge clock);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Release is part of every press, so later checks see a quiet port.
    task press(input logic [7:0] v, input int n);
        keys <= v;
        repeat (n) @(posedge clock);
        keys <= 8'hFF;
        repeat (4) @(posedge clock);
    endtask
    ////////////////////////////////////////
    task t_regs;
        rchk(port_match_pkg::addr_mask, 32'h0);
        chk(err, 32'h0);
        rchk(port_match_pkg::addr_pattern, 32'hFF);
        rchk(port_match_pkg::addr_port, 32'hFF);
        rchk(port_match_pkg::addr_control, 32'h0);
        apb(1'b1, 8'h18, 32'hFF);
        rchk(8'h18, 32'h0);
        chk(err, 32'h1);
        $display("t_regs done");
    endtask
    task t_keys;
        apb(1'b1, port_match_pkg::addr_mask, 32'h0F);
        apb(1'b1, port_match_pkg::addr_control, 32'h0E);
        low_power <= 1'b1;
        press(8'h7F, 20);
        chk(irq, 32'h0);
        press(8'hFE, 6);
        chk(irq, 32'h0);
        press(8'hFE, 7);
        chk(irq, 32'h1);
        chk(wake, 32'h1);
        apb(1'b1, port_match_pkg::addr_control, 32'h0E);
        repeat (3) @(posedge clock);
        chk(irq, 32'h0);
        chk(wake, 32'h0);
        $display("t_keys done");
    endtask
    task t_equal;
        low_power <= 1'b0;
        apb(1'b1, port_match_pkg::addr_status, 32'h3);
        apb(1'b1, port_match_pkg::addr_pattern, 32'h05);
        apb(1'b1, port_match_pkg::addr_control, 32'h04);
        press(8'hF6, 12);
        rchk(port_match_pkg::addr_control, 32'h04);
        press(8'hA5, 12);
        chk(irq, 32'h0);
        rchk(port_match_pkg::addr_control, 32'h05);
        rchk(port_match_pkg::addr_status, 32'h1);
        apb(1'b1, port_match_pkg::addr_irq_en, 32'h1);
        repeat (2) @(posedge clock);
        chk(irq, 32'h1);
        apb(1'b1, port_match_pkg::addr_status, 32'h1);
        apb(1'b1, port_match_pkg::addr_control, 32'h04);
        repeat (3) @(posedge clock);
        chk(irq, 32'h0);
        rchk(port_match_pkg::addr_control, 32'h04);
        $display("t_equal done");
    endtask
    // A matching pattern while the function is off must leave no trace.
    task t_idle;
        apb(1'b1, port_match_pkg::addr_control, 32'h00);
        press(8'hA5, 12);
        rchk(port_match_pkg::addr_control, 32'h0);
        rchk(port_match_pkg::addr_status, 32'h0);
        chk(irq, 32'h0);
        $display("t_idle done");
    endtask
    ////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_regs;
        t_keys;
        t_equal;
        t_idle;
        report_and_stop;
    end
    initial
    begin
        repeat (3000) @(posedge clock);
        bad_count++;
        report_and_stop;
    end
endmodule
